// ===== mcsr_pkg.sv
// package for the motor control state readback bank
// assumes a 32-bit classic wishbone slave with byte addressing
package mcsr_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_OL_SPEED = 12'h53c;
    localparam logic [11:0] IDX_OL_IQ = 12'h54c;
    localparam logic [11:0] IDX_CL_SPEED = 12'h5d2;
    localparam logic [11:0] IDX_CL_ID = 12'h604;
    localparam logic [11:0] IDX_CL_IQ = 12'h606;
    localparam logic [11:0] IDX_SD_PHASE = 12'h680;
    localparam logic [11:0] IDX_SD_RESULT = 12'h68a;
    localparam logic [11:0] IDX_PD_PHASE = 12'h6be;
    localparam logic [11:0] IDX_PD_ANGLE = 12'h702;
    localparam logic [11:0] IDX_BEMF_D = 12'h748;
    // interrupt registers, own indices
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h7f0;
    localparam logic [11:0] IDX_IRQ_ENABLE = 12'h7f1;
    localparam logic [11:0] IDX_IRQ_CLEAR = 12'h7f2;
    localparam int ADDR_W = 14;
    localparam int IDX_LSB = 2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [15:0] RESET_PHASE = 16'h0000;
    localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;
    // fixed point scale: value / 2^27
    localparam int FRAC_BITS = 27;
    // status bit positions
    localparam int IRQ_SD_DONE = 0;
    localparam int IRQ_SD_FAULT = 1;
    localparam int IRQ_PD_DONE = 2;
    localparam int IRQ_PD_FAULT = 3;
    localparam int IRQ_W = 4;
    typedef enum logic [15:0] {
        SD_INIT = 16'h0000,
        SD_STOP_CHECK = 16'h0001,
        SD_ESTIM_INIT = 16'h0002,
        SD_RUN_CHECK = 16'h0003,
        SD_DIR_CHECK = 16'h0004,
        SD_DONE = 16'h0005,
        SD_FAULT = 16'h0006
    } mcsr_sd_e;
    typedef enum logic [15:0] {
        PD_INIT = 16'h0000,
        PD_VECTOR_CONFIG = 16'h0001,
        PD_RUN = 16'h0002,
        PD_SLOW_RISE = 16'h0003,
        PD_SLOW_FALL = 16'h0004,
        PD_WAIT_DECAY = 16'h0005,
        PD_GET_TIMES = 16'h0006,
        PD_NEXT_VECTOR = 16'h0007,
        PD_SECTOR_RISE = 16'h0008,
        PD_ROTOR_POS = 16'h0009,
        PD_CALC_ANGLE = 16'h000a,
        PD_DONE = 16'h000b,
        PD_FAULT = 16'h000c
    } mcsr_pd_e;
endpackage

// ===== mcsr_readback.sv
// motor control state readback bank: read-only snapshot of algorithm variables
// assumes the algorithm core runs on clk_i and presents values plus an update strobe
`timescale 1ns/1ps
// Operation
// RULE1 - open-loop speed word, scaled 2^27 of max speed
// RULE2 - open-loop torque current, 2^27 of current/8
// RULE3 - closed-loop speed reference, 2^27 of max speed
// RULE4 - closed-loop flux current reference, 2^27 scaled
// RULE5 - closed-loop torque current reference, 2^27 scaled
// RULE6 - speed detection phase codes zero to six
// RULE7 - speed detection result word, 2^27 of max speed
// RULE8 - position detection phase codes zero to twelve
// RULE9 - position angle word, 2^27 of 360 degrees
// RULE10 - speed detection phase 16 bits, resets zero
// RULE11 - d-axis backemf word at 0x748, resets zero
// RULE12 - backemf word, 2^27 times 60 over root3
// RULE13 - all bank registers read-only, writes ignored; here enable writes store and clear writes drop status bits
module mcsr_readback
    import mcsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic upd_i,
    input wire logic [31:0] ol_speed_i,
    input wire logic [31:0] ol_iq_i,
    input wire logic [31:0] cl_speed_i,
    input wire logic [31:0] cl_id_i,
    input wire logic [31:0] cl_iq_i,
    input wire logic [15:0] sd_phase_i,
    input wire logic [31:0] sd_result_i,
    input wire logic [15:0] pd_phase_i,
    input wire logic [31:0] pd_angle_i,
    input wire logic [31:0] bemf_d_i
);
    typedef struct packed {
        logic [31:0] ol_speed;
        logic [31:0] ol_iq;
        logic [31:0] cl_speed;
        logic [31:0] cl_id;
        logic [31:0] cl_iq;
        logic [15:0] sd_phase;
        logic [31:0] sd_result;
        logic [15:0] pd_phase;
        logic [31:0] pd_angle;
        logic [31:0] bemf_d;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] enable;
        logic [31:0] dat;
        logic ack;
        logic irq;
    } mcsr_state_s;

    mcsr_state_s st_ff;
    mcsr_state_s nxt_st;
    logic [11:0] idx;
    logic req;
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] clr;
    logic wr_ok;

    assign idx = wb_adr_i[ADDR_W-1:IDX_LSB];
    // a fresh request only; ack high blocks a second answer to the same strobe
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;

    // a write lands at the edge where the master sees ack, so a dropped cycle stores nothing
    assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack;

    // sequence completion and fault events, taken on entry into the phase only
    always_comb
    begin
        evt = '0;
        if (upd_i)
        begin
            evt[IRQ_SD_DONE] = (sd_phase_i == SD_DONE) && (st_ff.sd_phase != SD_DONE);
            evt[IRQ_SD_FAULT] = (sd_phase_i == SD_FAULT) && (st_ff.sd_phase != SD_FAULT);
            evt[IRQ_PD_DONE] = (pd_phase_i == PD_DONE) && (st_ff.pd_phase != PD_DONE);
            evt[IRQ_PD_FAULT] = (pd_phase_i == PD_FAULT) && (st_ff.pd_phase != PD_FAULT);
        end
        clr = '0;
        if (wr_ok && idx == IDX_IRQ_CLEAR && wb_sel_i[0])
        begin
            clr = wb_dat_i[IRQ_W-1:0];
        end
    end

    // next state: snapshot capture, bus decode and interrupt bookkeeping
    always_comb
    begin
        nxt_st = st_ff;
        // values only change on the core strobe, never from the bus
        if (upd_i)
        begin
            nxt_st.ol_speed = ol_speed_i; // RULE1
            nxt_st.ol_iq = ol_iq_i; // RULE2
            nxt_st.cl_speed = cl_speed_i; // RULE3
            nxt_st.cl_id = cl_id_i; // RULE4
            nxt_st.cl_iq = cl_iq_i; // RULE5
            nxt_st.sd_phase = sd_phase_i; // RULE6
            nxt_st.sd_result = sd_result_i; // RULE7
            nxt_st.pd_phase = pd_phase_i; // RULE8
            nxt_st.pd_angle = pd_angle_i; // RULE9
            nxt_st.bemf_d = bemf_d_i; // RULE12
        end
        // set wins over clear when both land in one cycle
        nxt_st.status = (st_ff.status & ~clr) | evt;
        nxt_st.ack = req;
        nxt_st.dat = st_ff.dat;
        if (req && !wb_we_i)
        begin
            if (idx == IDX_OL_SPEED)
                nxt_st.dat = st_ff.ol_speed;
            else if (idx == IDX_OL_IQ)
                nxt_st.dat = st_ff.ol_iq;
            else if (idx == IDX_CL_SPEED)
                nxt_st.dat = st_ff.cl_speed;
            else if (idx == IDX_CL_ID)
                nxt_st.dat = st_ff.cl_id;
            else if (idx == IDX_CL_IQ)
                nxt_st.dat = st_ff.cl_iq;
            else if (idx == IDX_SD_PHASE)
                nxt_st.dat = {16'h0000, st_ff.sd_phase}; // RULE10
            else if (idx == IDX_SD_RESULT)
                nxt_st.dat = st_ff.sd_result;
            else if (idx == IDX_PD_PHASE)
                nxt_st.dat = {16'h0000, st_ff.pd_phase};
            else if (idx == IDX_PD_ANGLE)
                nxt_st.dat = st_ff.pd_angle;
            else if (idx == IDX_BEMF_D)
                nxt_st.dat = st_ff.bemf_d; // RULE11
            else if (idx == IDX_IRQ_STATUS)
                nxt_st.dat = {{(32-IRQ_W){1'b0}}, st_ff.status};
            else if (idx == IDX_IRQ_ENABLE)
                nxt_st.dat = {{(32-IRQ_W){1'b0}}, st_ff.enable};
            else
                nxt_st.dat = UNMAPPED_WORD;
        end
        // writes are acked everywhere but only the enable register stores
        if (wr_ok && idx == IDX_IRQ_ENABLE && wb_sel_i[0]) // RULE13
        begin
            nxt_st.enable = wb_dat_i[IRQ_W-1:0];
        end
        nxt_st.irq = |(nxt_st.status & nxt_st.enable);
    end

    // single register stage; synchronous reset clears everything
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0; // RULE10 RULE11
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign irq_o = st_ff.irq;

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    a_write_keeps_value: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        wb_cyc_i && wb_stb_i && wb_we_i && !upd_i |=> $stable(st_ff.bemf_d))
        else $error("bus write altered a readback value");
    a_bemf_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        req && !wb_we_i && idx == IDX_BEMF_D |=> wb_dat_o == $past(st_ff.bemf_d))
        else $error("backemf read returned wrong word");
    a_sd_phase_upper: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        wb_ack_o && $past(idx) == IDX_SD_PHASE && !$past(wb_we_i) |-> wb_dat_o[31:16] == 16'h0000)
        else $error("speed phase upper bits not zero");
    a_sd_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        upd_i |=> st_ff.sd_phase == $past(sd_phase_i) && st_ff.sd_result == $past(sd_result_i))
        else $error("speed detection capture missed");
    a_pd_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        upd_i |=> st_ff.pd_phase == $past(pd_phase_i) && st_ff.pd_angle == $past(pd_angle_i))
        else $error("position detection capture missed");
    a_ref_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        upd_i |=> st_ff.cl_speed == $past(cl_speed_i) && st_ff.ol_iq == $past(ol_iq_i))
        else $error("reference capture missed");
    a_irq_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        upd_i && sd_phase_i == SD_FAULT && st_ff.sd_phase != SD_FAULT |=> st_ff.status[IRQ_SD_FAULT])
        else $error("fault entry did not set status");

    // open-loop speed word follows its input one edge after the strobe
    a_ol_speed_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        upd_i
        |=> st_ff.ol_speed == $past(ol_speed_i))
        else $error("open-loop speed capture missed");

    // open-loop torque current follows its input
    a_ol_iq_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        upd_i
        |=> st_ff.ol_iq == $past(ol_iq_i))
        else $error("open-loop torque current capture missed");

    // closed-loop flux current reference follows its input
    a_cl_id_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        upd_i
        |=> st_ff.cl_id == $past(cl_id_i))
        else $error("flux current reference capture missed");

    // closed-loop torque current reference follows its input
    a_cl_iq_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        upd_i
        |=> st_ff.cl_iq == $past(cl_iq_i))
        else $error("torque current reference capture missed");

    // backemf word is passed through untouched; scaling is the reader's job
    a_bemf_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        upd_i
        |=> st_ff.bemf_d == $past(bemf_d_i))
        else $error("backemf capture missed");

    // without the core strobe the reference words never move
    a_refs_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        !upd_i
        |=> $stable(st_ff.ol_speed) && $stable(st_ff.ol_iq) && $stable(st_ff.cl_speed)
            && $stable(st_ff.cl_id) && $stable(st_ff.cl_iq))
        else $error("reference word moved without strobe");

    // without the core strobe the detection words never move
    a_detect_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        !upd_i
        |=> $stable(st_ff.sd_phase) && $stable(st_ff.sd_result) && $stable(st_ff.pd_phase)
            && $stable(st_ff.pd_angle) && $stable(st_ff.bemf_d))
        else $error("detection word moved without strobe");

    // each read returns the word held at the edge that took the request
    a_ol_speed_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        req && !wb_we_i && idx == IDX_OL_SPEED
        |=> wb_dat_o == $past(st_ff.ol_speed))
        else $error("open-loop speed read returned wrong word");

    // open-loop torque current read
    a_ol_iq_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        req && !wb_we_i && idx == IDX_OL_IQ
        |=> wb_dat_o == $past(st_ff.ol_iq))
        else $error("open-loop torque current read returned wrong word");

    // closed-loop speed reference read
    a_cl_speed_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        req && !wb_we_i && idx == IDX_CL_SPEED
        |=> wb_dat_o == $past(st_ff.cl_speed))
        else $error("closed-loop speed read returned wrong word");

    // flux current reference read
    a_cl_id_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        req && !wb_we_i && idx == IDX_CL_ID
        |=> wb_dat_o == $past(st_ff.cl_id))
        else $error("flux current reference read returned wrong word");

    // torque current reference read
    a_cl_iq_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        req && !wb_we_i && idx == IDX_CL_IQ
        |=> wb_dat_o == $past(st_ff.cl_iq))
        else $error("torque current reference read returned wrong word");

    // speed phase code comes back zero extended
    a_sd_phase_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        req && !wb_we_i && idx == IDX_SD_PHASE
        |=> wb_dat_o == 32'($past(st_ff.sd_phase)))
        else $error("speed phase read returned wrong word");

    // speed detection result read
    a_sd_result_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        req && !wb_we_i && idx == IDX_SD_RESULT
        |=> wb_dat_o == $past(st_ff.sd_result))
        else $error("speed result read returned wrong word");

    // position phase code comes back zero extended
    a_pd_phase_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        req && !wb_we_i && idx == IDX_PD_PHASE
        |=> wb_dat_o == 32'($past(st_ff.pd_phase)))
        else $error("position phase read returned wrong word");

    // position angle read
    a_pd_angle_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        req && !wb_we_i && idx == IDX_PD_ANGLE
        |=> wb_dat_o == $past(st_ff.pd_angle))
        else $error("position angle read returned wrong word");

    // reset clears the words; no disable here or the check could never run
    a_reset_zero: assert property (@(posedge clk_i) // RULE10
        rst_i
        |=> st_ff.sd_phase == RESET_PHASE && st_ff.bemf_d == RESET_WORD)
        else $error("reset left a readback word set");

    // reset also silences the bus answer and the interrupt
    a_reset_quiet: assert property (@(posedge clk_i) // RULE11
        rst_i
        |=> !wb_ack_o && !irq_o)
        else $error("reset left ack or interrupt high");

    // no answer without a request on the bus
    a_no_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        !wb_cyc_i || !wb_stb_i
        |=> !wb_ack_o)
        else $error("ack without a request");

    // writes to read-only words are still answered, so the master never hangs
    a_write_acked: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        req && wb_we_i
        |=> wb_ack_o)
        else $error("write was not acknowledged");

    // read data only changes when a read is taken
    a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        !(req && !wb_we_i)
        |=> $stable(wb_dat_o))
        else $error("read data moved without a read");

    // interrupt line mirrors enabled status bits
    a_irq_matches: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        ((st_ff.status & st_ff.enable) != '0)
        == irq_o)
        else $error("interrupt line disagrees with status");

    // entry into the speed done phase raises its status bit
    a_sd_done_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        upd_i && sd_phase_i == SD_DONE && st_ff.sd_phase != SD_DONE
        |=> st_ff.status[IRQ_SD_DONE])
        else $error("speed done entry did not set status");

    // entry into the position done phase raises its status bit
    a_pd_done_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        upd_i && pd_phase_i == PD_DONE && st_ff.pd_phase != PD_DONE
        |=> st_ff.status[IRQ_PD_DONE])
        else $error("position done entry did not set status");

    // entry into the position fault phase raises its status bit
    a_pd_fault_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        upd_i && pd_phase_i == PD_FAULT && st_ff.pd_phase != PD_FAULT
        |=> st_ff.status[IRQ_PD_FAULT])
        else $error("position fault entry did not set status");

    // status bits are sticky until software clears them
    a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        !(wr_ok && idx == IDX_IRQ_CLEAR)
        |=> (st_ff.status & $past(st_ff.status)) == $past(st_ff.status))
        else $error("status bit dropped without a clear");

    // a clear with no event in the same cycle empties the chosen bits
    a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        wr_ok && idx == IDX_IRQ_CLEAR && wb_sel_i[0] && !upd_i
        |=> (st_ff.status & $past(wb_dat_i[IRQ_W-1:0])) == '0)
        else $error("clear left a status bit set");

    // the enable mask only moves on its own register write
    a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        !(wr_ok && idx == IDX_IRQ_ENABLE)
        |=> $stable(st_ff.enable))
        else $error("enable mask moved without a write");

    // status read returns the sticky bits zero extended
    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        req && !wb_we_i && idx == IDX_IRQ_STATUS
        |=> wb_dat_o == 32'($past(st_ff.status)))
        else $error("status read returned wrong word");

    // enable read returns the mask zero extended
    a_enable_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        req && !wb_we_i && idx == IDX_IRQ_ENABLE
        |=> wb_dat_o == 32'($past(st_ff.enable)))
        else $error("enable read returned wrong word");
endmodule

// ===== mcsr_readback_tb_top.sv
// testbench for the motor control state readback bank
// assumes mcsr_readback with a classic wishbone slave clocked by clk_i
`timescale 1ns/1ps
module mcsr_readback_tb_top;
    import mcsr_pkg::*;
    typedef struct {logic [11:0] idx; logic [31:0] val;} mcsr_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic [31:0] wdat = '0;
    logic we = 1'b0;
    logic [3:0] sel = 4'hf;
    logic stb = 1'b0;
    logic upd = 1'b0;
    logic [31:0] v [10] = '{default: '0};
    wire logic [31:0] rdat;
    wire logic ack;
    wire logic irq;
    mcsr_row_s rows [10];
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] q;

    // byte enables come from the bus task; lane 0 gates the interrupt writes
    mcsr_readback dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .upd_i(upd), .ol_speed_i(v[0]), .ol_iq_i(v[1]),
        .cl_speed_i(v[2]), .cl_id_i(v[3]), .cl_iq_i(v[4]), .sd_phase_i(v[5][15:0]),
        .sd_result_i(v[6]), .pd_phase_i(v[7][15:0]), .pd_angle_i(v[8]), .bemf_d_i(v[9]));

    // free running clock, 8 ns period
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; request held until the edge that samples ack
    task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        @(posedge clk_i);
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        wdat <= d;
        // ack is seen at the edge itself, before that edge's update lands; the loop ends on ack, and only the timeout ends a missing one
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        q = rdat;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // capture strobe from the core; values were set at the previous edge
    task automatic pulse;
        @(posedge clk_i);
        upd <= 1'b1;
        @(posedge clk_i);
        upd <= 1'b0;
    endtask

    task automatic check_rows(input logic zero);
        foreach (rows[i])
        begin
            wb(1'b0, rows[i].idx, '0);
            chk32(q, zero ? RESET_WORD : rows[i].val);
        end
    endtask

    // main sequence; sign bit and fraction patterns in the value rows
    initial
    begin
        rows = '{'{IDX_OL_SPEED, 32'h0800_0000}, '{IDX_OL_IQ, 32'hf800_0001},
            '{IDX_CL_SPEED, 32'h0400_1234}, '{IDX_CL_ID, 32'h8000_0000},
            '{IDX_CL_IQ, 32'h7fff_ffff}, '{IDX_SD_PHASE, 32'h0000_0004},
            '{IDX_SD_RESULT, 32'h1357_9bdf}, '{IDX_PD_PHASE, 32'h0000_000a},
            '{IDX_PD_ANGLE, 32'h2d00_0000}, '{IDX_BEMF_D, 32'hfedc_ba98}};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check_rows(1'b1);
        foreach (rows[i]) v[i] <= rows[i].val;
        pulse();
        check_rows(1'b0);
        foreach (rows[i]) wb(1'b1, rows[i].idx, 32'hffff_ffff);
        check_rows(1'b0);
        wb(1'b0, 12'h7ff, '0);
        chk32(q, UNMAPPED_WORD);
        // walk every phase code; the ends of both walks raise status bits
        for (int c = 0; c <= 12; c++)
        begin
            v[5] <= 32'(c > 6 ? 6 : c);
            v[7] <= 32'(c);
            pulse();
            wb(1'b0, IDX_SD_PHASE, '0);
            chk32(q, 32'(c > 6 ? 6 : c));
            wb(1'b0, IDX_PD_PHASE, '0);
            chk32(q, 32'(c));
        end
        wb(1'b0, IDX_IRQ_STATUS, '0);
        chk32(q, 32'h0000_000f);
        chk1(irq, 1'b0);
        wb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0005);
        repeat (2) @(posedge clk_i);
        chk1(irq, 1'b1);
        // a write without byte lane 0 must leave the enable mask alone
        wb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0000, 4'h0);
        wb(1'b0, IDX_IRQ_ENABLE, '0);
        chk32(q, 32'h0000_0005);
        wb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk1(irq, 1'b1);
        wb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0004);
        repeat (2) @(posedge clk_i);
        chk1(irq, 1'b0);
        wb(1'b0, IDX_IRQ_STATUS, '0);
        chk32(q, 32'h0000_000a);
        // second reset in mid-run must zero every value again
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check_rows(1'b1);
        wb(1'b0, IDX_IRQ_STATUS, '0);
        chk32(q, 32'h0000_0000);
        chk1(irq, 1'b0);
        test_done();
    end
endmodule
